// ===== core/btt_trim_regs.sv
// Functional notes
// - in zero-degree phase each bank outputs its zero-degree trim code
// - in minus-ninety phase each bank outputs its minus-ninety code instead
// - after reset every register holds the factory trim code until written
// - software writes store the code, read back, and drive the adjustment
// - banks 1 to 4 decode as pairs 0x112/0x113 upward, spaced 0x10
// - bank 0 minus-ninety register decodes at 0x103, reset to 0x00 like every other register
// - bank 0 zero-degree at 0x102, bank 5 pair at 0x152/0x153
`include "btt_map.svh"

module btt_trim_regs
  import btt_pkg::*;
(
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // factory trim codes and phase configuration
  input  wire btt_code_t        fuse_zero   [6],
  input  wire btt_code_t        fuse_minus90[6],
  input  wire logic             phase_minus90,
  // delay control
  output btt_code_t             bank_adjust [6],
  output logic                  trim_ready
);

  // ************************************************************
  // address decode
  // ************************************************************

  function automatic btt_dec_s decode(input logic [11:0] addr);
    btt_dec_s d;
    btt_idx_t off;
    d   = '0;
    off = btt_idx_t'(addr[`BTT_IDX_MSB:`BTT_IDX_LSB] - `BTT_IDX_B0_ZERO);
    d.bank    = off[`BTT_BANK_MSB:`BTT_BANK_LSB];
    d.minus90 = off[`BTT_PHASE_BIT];
    d.valid   = (addr[`BTT_IDX_LSB-1:0] == 2'h0)
              && (off[`BTT_PAIR_MSB:`BTT_PAIR_LSB] == 3'h0)
              && (off[`BTT_HIGH_MSB:`BTT_HIGH_LSB] == 3'h0)
              && (d.bank < `BTT_NUM_BANKS);
    return d;
  endfunction

  btt_dec_s  dec;
  btt_code_t trim_zero    [6];
  btt_code_t trim_minus90 [6];
  logic      wr_done;
  logic      rd_setup;
  logic      next_pready;

  assign dec         = decode(paddr);
  assign wr_done     = psel && penable && pready && pwrite && !pslverr;
  assign rd_setup    = psel && !pready;
  assign next_pready = trim_ready && psel && !pready;

  function automatic btt_code_t read_code(input btt_dec_s d,
                                          input btt_code_t z [6],
                                          input btt_code_t m [6]);
    btt_code_t v;
    v = `BTT_CODE_RST;
    if (d.valid)
    begin
      v = d.minus90 ? m[d.bank] : z[d.bank];
    end
    return v;
  endfunction

  // ************************************************************
  // factory trim capture
  // ************************************************************

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trim_ready <= 1'b0;
    end
    else
    begin
      trim_ready <= 1'b1;
    end
  end

  // ************************************************************
  // trim registers and delay outputs
  // ************************************************************

  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_bank
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          trim_zero[g]    <= `BTT_CODE_RST;
          trim_minus90[g] <= `BTT_CODE_RST;
        end
        else if (!trim_ready)
        begin
          trim_zero[g]    <= fuse_zero[g];
          trim_minus90[g] <= fuse_minus90[g];
        end
        else if (wr_done && pstrb[0] && dec.bank == 3'(g))
        begin
          if (dec.minus90)
          begin
            trim_minus90[g] <= pwdata[7:0];
          end
          else
          begin
            trim_zero[g] <= pwdata[7:0];
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          bank_adjust[g] <= `BTT_CODE_RST;
        end
        else if (phase_minus90)
        begin
          bank_adjust[g] <= trim_minus90[g];
        end
        else
        begin
          bank_adjust[g] <= trim_zero[g];
        end
      end

      a_zero_phase_out : assert property (@(posedge pclk) disable iff (!presetn)
        !phase_minus90 |=> bank_adjust[g] == $past(trim_zero[g]))
        else $error("zero-degree code not applied");

      a_m90_phase_out : assert property (@(posedge pclk) disable iff (!presetn)
        phase_minus90 |=> bank_adjust[g] == $past(trim_minus90[g]))
        else $error("minus-ninety code not applied");

      a_write_stores : assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && pstrb[0] && dec.bank == 3'(g)
        |=> ($past(dec.minus90) ? trim_minus90[g] : trim_zero[g]) == $past(pwdata[7:0]))
        else $error("written code not stored");

      a_fuse_bank : assert property (@(posedge pclk) disable iff (!presetn)
        $rose(trim_ready) |-> trim_zero[g] == $past(fuse_zero[g])
                           && trim_minus90[g] == $past(fuse_minus90[g]))
        else $error("factory trim not captured for bank");

      a_strobe_gates : assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && !pstrb[0] && trim_ready
        |=> $stable(trim_zero[g]) && $stable(trim_minus90[g]))
        else $error("write without byte strobe changed a code");

      a_error_keeps : assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pslverr && trim_ready
        |=> $stable(trim_zero[g]) && $stable(trim_minus90[g]))
        else $error("refused access changed a code");

      a_other_bank : assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && dec.bank != 3'(g)
        |=> $stable(trim_zero[g]) && $stable(trim_minus90[g]))
        else $error("write to one bank changed another");

      a_write_drives : assert property (@(posedge pclk) disable iff (!presetn)
        wr_done && pstrb[0] && dec.bank == 3'(g) && !dec.minus90 && !phase_minus90
        ##1 !phase_minus90 |=> bank_adjust[g] == $past(pwdata[7:0], 2))
        else $error("written code not driven to bank");
    end
  endgenerate

  // ************************************************************
  // apb response
  // ************************************************************

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= `BTT_DATA_RST;
      pslverr <= 1'b0;
    end
    else if (next_pready)
    begin
      pslverr <= !dec.valid;
      prdata  <= (rd_setup && !pwrite)
               ? {24'h00_0000, read_code(dec, trim_zero, trim_minus90)}
               : `BTT_DATA_RST;
    end
    else if (!psel)
    begin
      prdata  <= `BTT_DATA_RST;
      pslverr <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************

  a_fuse_capture : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(trim_ready) |-> trim_zero[0] == $past(fuse_zero[0])
                       && trim_minus90[5] == $past(fuse_minus90[5]))
    else $error("factory trim not captured");

  a_read_back : assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && !pwrite && !pslverr
    |-> prdata[7:0] == read_code(dec, trim_zero, trim_minus90) && prdata[31:8] == 24'h0)
    else $error("read data differs from stored code");

  a_decode_bank1 : assert property (@(posedge pclk) disable iff (!presetn)
    psel && paddr[`BTT_IDX_MSB:`BTT_IDX_LSB] == `BTT_IDX_B1_M90 && paddr[1:0] == 2'h0
    |-> dec.valid && dec.bank == 3'h1 && dec.minus90)
    else $error("bank 1 minus-ninety decode wrong");

  a_decode_bank0 : assert property (@(posedge pclk) disable iff (!presetn)
    psel && paddr[`BTT_IDX_MSB:`BTT_IDX_LSB] == `BTT_IDX_B0_M90 && paddr[1:0] == 2'h0
    |-> dec.valid && dec.bank == 3'h0 && dec.minus90)
    else $error("bank 0 minus-ninety decode wrong");

  a_decode_bank5 : assert property (@(posedge pclk) disable iff (!presetn)
    psel && paddr[`BTT_IDX_MSB:`BTT_IDX_LSB] == `BTT_IDX_B5_ZERO && paddr[1:0] == 2'h0
    |-> dec.valid && dec.bank == 3'h5 && !dec.minus90)
    else $error("bank 5 zero-degree decode wrong");

  a_decode_bank2 : assert property (@(posedge pclk) disable iff (!presetn)
    psel && paddr[`BTT_IDX_MSB:`BTT_IDX_LSB] == `BTT_IDX_B2_ZERO && paddr[1:0] == 2'h0
    |-> dec.valid && dec.bank == 3'h2 && !dec.minus90)
    else $error("bank 2 zero-degree decode wrong");

  a_decode_bank3 : assert property (@(posedge pclk) disable iff (!presetn)
    psel && paddr[`BTT_IDX_MSB:`BTT_IDX_LSB] == `BTT_IDX_B3_M90 && paddr[1:0] == 2'h0
    |-> dec.valid && dec.bank == 3'h3 && dec.minus90)
    else $error("bank 3 minus-ninety decode wrong");

  a_decode_bank4 : assert property (@(posedge pclk) disable iff (!presetn)
    psel && paddr[`BTT_IDX_MSB:`BTT_IDX_LSB] == `BTT_IDX_B4_M90 && paddr[1:0] == 2'h0
    |-> dec.valid && dec.bank == 3'h4 && dec.minus90)
    else $error("bank 4 minus-ninety decode wrong");

  a_decode_bank0z : assert property (@(posedge pclk) disable iff (!presetn)
    psel && paddr[`BTT_IDX_MSB:`BTT_IDX_LSB] == `BTT_IDX_B0_ZERO && paddr[1:0] == 2'h0
    |-> dec.valid && dec.bank == 3'h0 && !dec.minus90)
    else $error("bank 0 zero-degree decode wrong");

  a_decode_bank5m : assert property (@(posedge pclk) disable iff (!presetn)
    psel && paddr[`BTT_IDX_MSB:`BTT_IDX_LSB] == `BTT_IDX_B5_M90 && paddr[1:0] == 2'h0
    |-> dec.valid && dec.bank == 3'h5 && dec.minus90)
    else $error("bank 5 minus-ninety decode wrong");

  a_idle_quiet : assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> !pready && !pslverr && prdata == `BTT_DATA_RST)
    else $error("bus outputs active while idle");

  a_write_no_data : assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && pwrite && trim_ready && !pready |=> prdata == `BTT_DATA_RST)
    else $error("read data driven during write");

  a_error_flag : assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && trim_ready && !pready && !dec.valid |=> pready && pslverr)
    else $error("unmapped setup not refused");

  a_ready_held : assert property (@(posedge pclk) disable iff (!presetn)
    !trim_ready |-> !pready)
    else $error("ready before factory trim captured");

  a_unmapped_err : assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && !dec.valid |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");

  a_ready_pulse : assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && trim_ready && !pready |=> pready ##1 !pready)
    else $error("ready not a single cycle pulse");

  a_code_opaque : assert property (@(posedge pclk) disable iff (!presetn)
    $stable(phase_minus90) && $stable(trim_zero[3]) && $stable(trim_minus90[3])
    ##1 1'b1 |-> $stable(bank_adjust[3]))
    else $error("trim code altered on its way out");

  c_write_zero : cover property (@(posedge pclk) disable iff (!presetn)
    wr_done && !dec.minus90);

  c_write_m90 : cover property (@(posedge pclk) disable iff (!presetn)
    wr_done && dec.minus90);

  c_read_hit : cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && !pwrite && !pslverr);

  c_phase_swap : cover property (@(posedge pclk) disable iff (!presetn)
    $changed(phase_minus90) && trim_zero[0] != trim_minus90[0]);

  c_refused : cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pready && pslverr);

endmodule

// ===== core/btt_map.svh
`ifndef BTT_MAP_SVH
`define BTT_MAP_SVH

// register indices; byte address is four times the index
`define BTT_IDX_B0_ZERO   10'h102
`define BTT_IDX_B0_M90    10'h103
`define BTT_IDX_B1_ZERO   10'h112
`define BTT_IDX_B1_M90    10'h113
`define BTT_IDX_B2_ZERO   10'h122
`define BTT_IDX_B2_M90    10'h123
`define BTT_IDX_B3_ZERO   10'h132
`define BTT_IDX_B3_M90    10'h133
`define BTT_IDX_B4_ZERO   10'h142
`define BTT_IDX_B4_M90    10'h143
`define BTT_IDX_B5_ZERO   10'h152
`define BTT_IDX_B5_M90    10'h153

// bank pair layout relative to bank 0 zero-degree index
`define BTT_BANK_LSB      4
`define BTT_BANK_MSB      6
`define BTT_PAIR_LSB      1
`define BTT_PAIR_MSB      3
`define BTT_HIGH_LSB      7
`define BTT_HIGH_MSB      9
`define BTT_PHASE_BIT     0
`define BTT_NUM_BANKS     3'h6

// byte address split
`define BTT_IDX_LSB       2
`define BTT_IDX_MSB       11

// reset values
`define BTT_CODE_RST      8'h00
`define BTT_DATA_RST      32'h0000_0000

`endif

// ===== core/btt_pkg.sv
package btt_pkg;

  typedef logic [7:0] btt_code_t;
  typedef logic [9:0] btt_idx_t;

  typedef struct packed
  {
    logic       valid;
    logic [2:0] bank;
    logic       minus90;
  } btt_dec_s;

endpackage

// ===== test/tb.sv
module tb
  import btt_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // stimulus and expectation state
  // ********
  logic        pclk          = 1'b0;
  logic        presetn       = 1'b0;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic        phase_minus90 = 1'b0;
  logic [11:0] paddr         = 12'h000;
  logic [31:0] pwdata        = 32'h0;
  logic [3:0]  pstrb         = 4'hf;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trim_ready;
  btt_code_t   fuse_zero   [6];
  btt_code_t   fuse_minus90[6];
  btt_code_t   bank_adjust [6];
  btt_code_t   cz          [6];
  btt_code_t   cm          [6];
  logic [32:0] q[$];
  logic [11:0] bad [7] = '{12'h404, 12'h410, 12'h550, 12'h588, 12'hc08, 12'h409, 12'h40e};
  int          n_errors = 0;
  int          compares = 0;
  integer      seed     = 32'h0792;

  always #12.5 pclk = ~pclk;

  btt_trim_regs dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuse_zero(fuse_zero), .fuse_minus90(fuse_minus90),
    .phase_minus90(phase_minus90), .bank_adjust(bank_adjust), .trim_ready(trim_ready)
  );

  // ********
  // tasks
  // ********
  function automatic logic [11:0] ad(int b, logic ph);
    return {10'h102 + 10'(b * 16) + {9'h0, ph}, 2'b00};
  endfunction

  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(posedge pclk);
    q.push_back({e, w ? 32'h0 : d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic read_all;
    for (int b = 0; b < 6; b++)
      for (int p = 0; p < 2; p++)
        xfer(1'b0, ad(b, p[0]), {24'h0, p ? cm[b] : cz[b]}, 1'b0);
  endtask

  task automatic adj;
    repeat (2) @(posedge pclk);
    #1;
    for (int b = 0; b < 6; b++)
      chk({25'h0, bank_adjust[b]}, {25'h0, phase_minus90 ? cm[b] : cz[b]});
  endtask

  task automatic complete_run;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
      chk({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());

  initial
  begin
    #100000;
    n_errors++;
    complete_run;
  end

  initial
  begin
    logic [31:0] d;
    for (int i = 0; i < 6; i++)
    begin
      fuse_zero[i] = 8'($random(seed));
      fuse_minus90[i] = 8'($random(seed));
    end
    cz = fuse_zero;
    cm = fuse_minus90;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk({32'h0, trim_ready}, 33'h1);
    adj;
    read_all;
    $display("test 1 factory codes done");
    @(posedge pclk);
    phase_minus90 <= 1'b1;
    adj;
    $display("test 2 phase select done");
    for (int b = 0; b < 6; b++)
      for (int p = 0; p < 2; p++)
      begin
        d = $random(seed);
        xfer(1'b1, ad(b, p[0]), d, 1'b0);
        if (p == 1)
          cm[b] = d[7:0];
        else
          cz[b] = d[7:0];
      end
    read_all;
    adj;
    @(posedge pclk);
    phase_minus90 <= 1'b0;
    adj;
    $display("test 3 write readback done");
    foreach (bad[i])
      xfer(1'b0, bad[i], 32'h0, 1'b1);
    xfer(1'b1, 12'h450, 32'hff, 1'b1);
    pstrb <= 4'h0;
    xfer(1'b1, ad(1, 1'b0), 32'h5a, 1'b0);
    pstrb <= 4'hf;
    read_all;
    adj;
    $display("test 4 refused access done");
    complete_run;
  end
endmodule
